// ### src/sram_pin_pkg.sv
// Purpose: Shared constants and types for the pipelined SRAM pin control block
// Assumes: 32-bit AHB-Lite register port, word aligned registers
// Notes:   Offsets are byte addresses on the register bus
package sram_pin_pkg;
   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int         LANE_DW   = 8;
   localparam int         BURST_W   = 2;
   localparam logic [1:0] BURST_ONE = 2'h1;
   localparam logic [1:0] BURST_ZERO = 2'h0;
   localparam int         LOG_DEPTH = 8;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_STATUS    = 8'h04;
   localparam logic [7:0] OFF_WR_COUNT  = 8'h08;
   localparam logic [7:0] OFF_LOG_DATA  = 8'h0c;
   localparam logic [7:0] OFF_LOG_LEVEL = 8'h10;
   localparam int         CTRL_FLOAT_BIT = 0;
   localparam logic       CTRL_FLOAT_RST = 1'b0;
   localparam int         STS_ACTIVE_BIT = 0;
   localparam int         STS_IL_BIT     = 1;
   localparam int         STS_DRIVE_BIT  = 2;
   localparam int         STS_OVF_BIT    = 3;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
   localparam logic [31:0] WORD_ONE     = 32'h0000_0001;

   // ---------------------------------------------------------------
   // Bus encodings
   // ---------------------------------------------------------------
   localparam int   HTRANS_ACT_BIT = 1;
   localparam logic HRESP_OKAY     = 1'b0;

   // Gray along idle -> read -> write
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b11
   } op_state_t;
endpackage : sram_pin_pkg

// ### src/sram_lane_mem.sv
// Purpose: Lane-writable storage array with registered read data
// Assumes: One port; read and write share the enabled edge
// Notes:   No reset, contents are undefined until written
`timescale 1ns/1ps
module sram_lane_mem #(
   parameter int ADDR_W = 19,
   parameter int LANES  = 8,
   parameter int LANE_W = 9
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_en,
   input  wire logic [ADDR_W-1:0]         i_addr,
   input  wire logic [LANES-1:0]          i_we,
   input  wire logic [LANES*LANE_W-1:0]   i_wdata,
   output logic      [LANES*LANE_W-1:0]   o_rdata
);
   if (ADDR_W < 1 || LANES < 1 || LANE_W < 1) begin : g_bad_param
      $error("sram_lane_mem: ADDR_W, LANES and LANE_W must be at least 1");
   end

   logic [LANE_W-1:0] mem_q [LANES][2**ADDR_W];

   for (genvar l = 0; l < LANES; l++) begin : g_lane
      always_ff @(posedge i_clk) begin
         if (i_en) begin
            if (i_we[l]) begin
               mem_q[l][i_addr] <= i_wdata[l*LANE_W +: LANE_W];
            end
            o_rdata[l*LANE_W +: LANE_W] <= mem_q[l][i_addr];
         end
      end
   end
endmodule : sram_lane_mem

// ### src/sram_log_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Full is a flop so the fill side sees a registered ready
`timescale 1ns/1ps
module sram_log_fifo #(
   parameter int W     = 19,
   parameter int DEPTH = 8
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_n,
   // Fill side
   input  wire logic                       i_valid,
   output logic                            o_ready,
   input  wire logic [W-1:0]               i_data,
   // Drain side
   output logic                            o_valid,
   input  wire logic                       i_ready,
   output logic      [W-1:0]               o_data,
   output logic      [$clog2(DEPTH+1)-1:0] o_level
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("sram_log_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0]  buf_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [CW-1:0] cnt_q;
   logic          full_q;
   logic          push;
   logic          pop;

   assign push    = i_valid & ~full_q;
   assign pop     = i_ready & (cnt_q != '0);
   assign o_ready = ~full_q;
   assign o_valid = (cnt_q != '0);
   assign o_data  = buf_q[rp_q];
   assign o_level = cnt_q;

   always_ff @(posedge i_clk) begin
      if (push) begin
         buf_q[wp_q] <= i_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wp_q   <= '0;
         rp_q   <= '0;
         cnt_q  <= '0;
         full_q <= 1'b0;
      end else begin
         if (push) begin
            wp_q <= wp_q + PW'(1);
         end
         if (pop) begin
            rp_q <= rp_q + PW'(1);
         end
         if (push && !pop) begin
            cnt_q  <= cnt_q + CW'(1);
            full_q <= (cnt_q == CW'(DEPTH - 1));
         end else if (pop && !push) begin
            cnt_q  <= cnt_q - CW'(1);
            full_q <= 1'b0;
         end
      end
   end
endmodule : sram_log_fifo

// ### src/sram_pin_ctrl.sv
// Purpose: Pin-level behaviour of a pipelined burst SRAM with a status port
// Assumes: Pins synchronous to i_clk; the output enable pin acts without clock
// Notes:   Data out follows the registered address by one qualified edge
//
// Function
// - Inputs captured only on rising clock edge
// - Edge ignored unless clock qualify is low
// - Qualify high holds state, is not deselect
// - Selected only when all three selects active
// - Output enable acts asynchronously with internal masking
// - Output enable high floats data and parity
// - Float on write data, re-select, deselect
// - Write data loaded on the rising edge
// - Read data from previously registered address
// - Parity lanes behave as data, byte-qualified
// - Strap high interleaved, low linear
// - Unconnected strap behaves as interleaved
// - Advance steps burst; load needed after deselect
// - Byte selects enable their own lane only
// - Burst walks two low address bits, wraps
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module sram_pin_ctrl
   import sram_pin_pkg::*;
#(
   parameter int ADDR_W = 19,
   parameter int LANES  = 8
) (
   // Clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   // Memory-side control
   input  wire logic [ADDR_W-1:0]      i_addr,
   input  wire logic                   i_clock_qualify_n,
   input  wire logic                   i_chip_sel_low_a,
   input  wire logic                   i_chip_sel_high,
   input  wire logic                   i_chip_sel_low_b,
   input  wire logic                   i_write_req_n,
   input  wire logic                   i_advance_or_load,
   input  wire logic [LANES-1:0]       i_byte_write_sel_n,
   input  wire logic                   i_out_en_n,
   input  wire logic                   i_burst_mode,
   // Data and parity pins
   input  wire logic [LANES*LANE_DW-1:0] i_dq,
   output logic      [LANES*LANE_DW-1:0] o_dq,
   output logic                        o_dq_oe_n,
   input  wire logic [LANES-1:0]       i_parity_io,
   output logic      [LANES-1:0]       o_parity_io,
   output logic                        o_parity_io_oe_n,
   // AHB-Lite register port
   input  wire logic                   i_hsel,
   input  wire logic [31:0]            i_haddr,
   input  wire logic [1:0]             i_htrans,
   input  wire logic                   i_hwrite,
   input  wire logic [2:0]             i_hsize,
   input  wire logic [31:0]            i_hwdata,
   input  wire logic                   i_hready,
   output logic      [31:0]            o_hrdata,
   output logic                        o_hreadyout,
   output logic                        o_hresp,
   // Write log back-pressure
   output logic                        o_log_ready
);
   localparam int LANE_W = LANE_DW + 1;
   localparam int LVL_W  = $clog2(LOG_DEPTH + 1);

   if (ADDR_W <= BURST_W || ADDR_W > 30 || LANES < 1) begin : g_bad_param
      $error("sram_pin_ctrl: ADDR_W must exceed the burst field, LANES >= 1");
   end

   // ---------------------------------------------------------------
   // Burst and access state
   // ---------------------------------------------------------------
   op_state_t          state_q;
   logic [ADDR_W-1:0]  base_q;
   logic [BURST_W-1:0] cnt_q;
   logic [LANES-1:0]   bw_n_q;
   logic               strap_q;
   logic               float_q;
   logic               burst_il;
   logic               sel;
   logic               edge_ok;
   logic [BURST_W-1:0] low_bits;
   logic [ADDR_W-1:0]  op_addr;
   logic               drive_q;
   logic               wr_next;

   assign edge_ok  = ~i_clock_qualify_n;
   assign sel      = ~i_chip_sel_low_a & i_chip_sel_high & ~i_chip_sel_low_b;
   assign burst_il = strap_q | float_q;
   // This edge opens a write data phase: a loaded write or a write burst step
   assign wr_next  = i_advance_or_load ? (state_q == ST_WRITE) : (sel & ~i_write_req_n);

   always_comb begin
      if (burst_il) begin
         low_bits = base_q[BURST_W-1:0] ^ cnt_q;
      end else begin
         low_bits = base_q[BURST_W-1:0] + cnt_q;
      end
   end
   assign op_addr = {base_q[ADDR_W-1:BURST_W], low_bits};

   // Strap is sampled while reset is held; it must not move afterwards
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         strap_q <= i_burst_mode;
      end
   end

   // Address, controls and lane selects enter only on a qualified edge
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_q <= ST_IDLE;
         base_q  <= '0;
         cnt_q   <= BURST_ZERO;
         bw_n_q  <= '1;
      end else if (edge_ok) begin
         if (!i_advance_or_load) begin
            if (sel) begin
               state_q <= i_write_req_n ? ST_READ : ST_WRITE;
               base_q  <= i_addr;
               cnt_q   <= BURST_ZERO;
               bw_n_q  <= i_byte_write_sel_n;
            end else begin
               state_q <= ST_IDLE;
            end
         end else if (state_q != ST_IDLE) begin
            cnt_q  <= cnt_q + BURST_ONE;
            bw_n_q <= i_byte_write_sel_n;
         end
      end
   end

   // ---------------------------------------------------------------
   // Storage and pins
   // ---------------------------------------------------------------
   logic [LANES-1:0]        lane_we;
   logic [LANES*LANE_W-1:0] wdata;
   logic [LANES*LANE_W-1:0] rdata;

   // Lanes open only for a write op, one per low byte select
   assign lane_we = (state_q == ST_WRITE) ? ~bw_n_q : '0;

   for (genvar l = 0; l < LANES; l++) begin : g_pack
      assign wdata[l*LANE_W +: LANE_W] = {i_parity_io[l], i_dq[l*LANE_DW +: LANE_DW]};
      assign o_dq[l*LANE_DW +: LANE_DW] = rdata[l*LANE_W +: LANE_DW];
      assign o_parity_io[l] = rdata[l*LANE_W + LANE_DW];
   end

   sram_lane_mem #(
      .ADDR_W (ADDR_W),
      .LANES  (LANES),
      .LANE_W (LANE_W)
   ) u_mem (
      .i_clk   (i_clk),
      .i_en    (edge_ok),
      .i_addr  (op_addr),
      .i_we    (lane_we),
      .i_wdata (wdata),
      .o_rdata (rdata)
   );

   // Drivers open only in the cycle after a read's data edge; a write loaded
   // right behind a read owns that cycle, so that read's data is never driven
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         drive_q <= 1'b0;
      end else if (edge_ok) begin
         drive_q <= (state_q == ST_READ) & ~wr_next;
      end
   end

   // The enable pin is not registered: it must float the bus at once
   assign o_dq_oe_n        = ~drive_q | i_out_en_n;
   assign o_parity_io_oe_n = ~drive_q | i_out_en_n;

   // ---------------------------------------------------------------
   // Write log and counters
   // ---------------------------------------------------------------
   logic              log_push;
   logic              log_ready;
   logic              log_valid;
   logic              log_pop;
   logic [ADDR_W-1:0] log_data;
   logic [LVL_W-1:0]  log_level;
   logic [31:0]       wr_cnt_q;
   logic              ovf_q;
   logic              ovf_clr;

   assign log_push    = edge_ok & (state_q == ST_WRITE);
   assign o_log_ready = log_ready;

   sram_log_fifo #(
      .W     (ADDR_W),
      .DEPTH (LOG_DEPTH)
   ) u_log (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_valid (log_push),
      .o_ready (log_ready),
      .i_data  (op_addr),
      .o_valid (log_valid),
      .i_ready (log_pop),
      .o_data  (log_data),
      .o_level (log_level)
   );

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_cnt_q <= WORD_ZERO;
      end else if (log_push) begin
         wr_cnt_q <= wr_cnt_q + WORD_ONE;
      end
   end

   // A lost log entry wins over a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ovf_q <= 1'b0;
      end else if (log_push && !log_ready) begin
         ovf_q <= 1'b1;
      end else if (ovf_clr) begin
         ovf_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ---------------------------------------------------------------
   logic        acc;
   logic        wr_pend_q;
   logic [7:0]  wr_off_q;
   logic [31:0] rd_word;
   logic [31:0] hrdata_q;

   assign acc     = i_hsel & i_hready & i_htrans[HTRANS_ACT_BIT];
   assign log_pop = acc & ~i_hwrite & (i_haddr[7:0] == OFF_LOG_DATA);
   assign ovf_clr = wr_pend_q & (wr_off_q == OFF_STATUS) & i_hwdata[STS_OVF_BIT];

   always_comb begin
      rd_word = WORD_ZERO;
      case (i_haddr[7:0])
         OFF_CTRL: begin
            rd_word[CTRL_FLOAT_BIT] = float_q;
         end
         OFF_STATUS: begin
            rd_word[STS_ACTIVE_BIT] = (state_q != ST_IDLE);
            rd_word[STS_IL_BIT]     = burst_il;
            rd_word[STS_DRIVE_BIT]  = drive_q;
            rd_word[STS_OVF_BIT]    = ovf_q;
         end
         OFF_WR_COUNT: begin
            rd_word = wr_cnt_q;
         end
         OFF_LOG_DATA: begin
            rd_word = log_valid ? 32'(log_data) : WORD_ZERO;
         end
         OFF_LOG_LEVEL: begin
            rd_word = 32'(log_level);
         end
         default: begin
            rd_word = WORD_ZERO;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         hrdata_q  <= WORD_ZERO;
         wr_pend_q <= 1'b0;
         wr_off_q  <= OFF_CTRL;
      end else begin
         wr_pend_q <= acc & i_hwrite;
         if (acc) begin
            wr_off_q <= i_haddr[7:0];
         end
         if (acc && !i_hwrite) begin
            hrdata_q <= rd_word;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         float_q <= CTRL_FLOAT_RST;
      end else if (wr_pend_q && wr_off_q == OFF_CTRL) begin
         float_q <= i_hwdata[CTRL_FLOAT_BIT];
      end
   end

   assign o_hrdata    = hrdata_q;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = HRESP_OKAY;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_load_sel;
      edge_ok && !i_advance_or_load && sel;
   endsequence
   sequence s_read_issue;
      s_load_sel and i_write_req_n;
   endsequence

   property p_hold_unqualified;
      !edge_ok |=> $stable(state_q) && $stable(cnt_q) && $stable(drive_q);
   endproperty
   a_hold_unqualified: assert property (p_hold_unqualified)
      else $error("state moved on an unqualified edge");

   property p_select_decode;
      edge_ok && !i_advance_or_load |=> (state_q != ST_IDLE) == $past(sel);
   endproperty
   a_select_decode: assert property (p_select_decode)
      else $error("select decode wrong");

   property p_oe_floats;
      i_out_en_n |-> o_dq_oe_n && o_parity_io_oe_n;
   endproperty
   a_oe_floats: assert property (p_oe_floats)
      else $error("pins driven with output enable high");

   property p_write_phase_float;
      state_q == ST_WRITE |-> o_dq_oe_n && o_parity_io_oe_n;
   endproperty
   a_write_phase_float: assert property (p_write_phase_float)
      else $error("drivers on during write data");

   property p_read_pipeline;
      s_read_issue ##1 (edge_ok && !wr_next) |=> drive_q && (o_dq_oe_n == i_out_en_n);
   endproperty
   a_read_pipeline: assert property (p_read_pipeline)
      else $error("read data not driven one edge later");

   property p_lane_write;
      state_q == ST_WRITE |-> lane_we == ~bw_n_q;
   endproperty
   a_lane_write: assert property (p_lane_write)
      else $error("lane write enable mismatch");

   property p_no_advance_after_deselect;
      edge_ok && state_q == ST_IDLE && i_advance_or_load |=> state_q == ST_IDLE;
   endproperty
   a_no_advance_after_deselect: assert property (p_no_advance_after_deselect)
      else $error("advance woke a deselected device");

   property p_burst_wrap;
      s_load_sel ##1 (edge_ok && i_advance_or_load) [*4] |=> cnt_q == BURST_ZERO;
   endproperty
   a_burst_wrap: assert property (p_burst_wrap)
      else $error("burst counter did not wrap after four");

   property p_float_interleaves;
      float_q |-> low_bits == (base_q[BURST_W-1:0] ^ cnt_q);
   endproperty
   a_float_interleaves: assert property (p_float_interleaves)
      else $error("floating strap not interleaved");

   property p_write_counted;
      edge_ok && state_q == ST_WRITE |=> wr_cnt_q == $past(wr_cnt_q) + WORD_ONE;
   endproperty
   a_write_counted: assert property (p_write_counted)
      else $error("write data edge not counted");
endmodule : sram_pin_ctrl

// ### sim/sram_ctrl_model.sv
// Purpose: Memory controller model that drives the SRAM pins of the block
// Assumes: One beat per call; pins change just after a rising edge
// Notes:   A released data bus shows the inverse of the wd given to the current beat
`timescale 1ns/1ps
module sram_ctrl_model #(
   parameter int AW = 6
) (
   // Clock
   input  wire logic          i_clk,
   // Device data pins as driven by the block
   input  wire logic [71:0]   i_dev_dq,
   input  wire logic          i_dq_oe_n,
   input  wire logic          i_par_oe_n,
   // Controller pins
   output logic      [AW-1:0] o_addr,
   output logic               o_cen_n,
   output logic      [2:0]    o_sel,
   output logic               o_we_n,
   output logic               o_adv,
   output logic      [7:0]    o_bw_n,
   output logic               o_oe_n,
   output logic      [71:0]   o_bus
);
   logic        drv_q;
   logic [71:0] wd_q;

   // ------------------------------------------------------------
   // Bus resolution
   // ------------------------------------------------------------
   // Undriven lines must not keep the old value, so show its inverse
   assign o_bus[63:0]  = !i_dq_oe_n ? i_dev_dq[63:0] :
                         (drv_q ? wd_q[63:0] : ~wd_q[63:0]);
   assign o_bus[71:64] = !i_par_oe_n ? i_dev_dq[71:64] :
                         (drv_q ? wd_q[71:64] : ~wd_q[71:64]);

   initial begin
      o_addr = '0;
      o_cen_n = 1'b0;
      o_sel = 3'b110;
      o_we_n = 1'b1;
      o_adv = 1'b0;
      o_bw_n = 8'hff;
      o_oe_n = 1'b0;
      drv_q = 1'b0;
      wd_q = '0;
   end

   // ------------------------------------------------------------
   // One clock beat of pin activity
   // ------------------------------------------------------------
   task automatic beat(input logic cen_n, input logic [2:0] sel, input logic adv,
                       input logic we_n, input logic [7:0] bw_n, input logic [AW-1:0] a,
                       input logic drv, input logic [71:0] wd);
      @(posedge i_clk);
      o_cen_n <= cen_n;
      o_sel <= sel;
      o_adv <= adv;
      o_we_n <= we_n;
      o_bw_n <= bw_n;
      o_addr <= a;
      drv_q <= drv;
      wd_q <= wd;
      #1;
   endtask : beat

   // Output enable is asynchronous, so it changes at once
   task automatic set_oe(input logic v);
      o_oe_n = v;
      #1;
   endtask : set_oe
endmodule : sram_ctrl_model

// ### sim/testbench.sv
// Purpose: Self-checking bench for the SRAM pin block and its register port
// Assumes: Controller model drives the pins; bench is the bus master
// Notes:   Address width shrunk to 6 bits to keep the array small
`timescale 1ns/1ps
module testbench;
   import sram_pin_pkg::*;
   localparam int         AW  = 6;
   localparam logic [2:0] SEL = 3'b010;
   logic             i_clk, i_rst_n, i_burst_mode, i_hsel, i_hwrite;
   logic [31:0]      i_haddr, i_hwdata, r;
   logic [1:0]       i_htrans;
   logic [2:0]       i_hsize;
   logic [AW-1:0]    addr;
   logic             cen_n, we_n, adv, oe_n;
   logic [2:0]       sel;
   logic [7:0]       bw_n, o_parity_io;
   logic [71:0]      bus;
   logic [63:0]      o_dq;
   logic             o_dq_oe_n, o_parity_io_oe_n, o_hreadyout, o_hresp, o_log_ready;
   logic [31:0]      o_hrdata;
   logic [2:0]       bad [3] = '{3'b110, 3'b000, 3'b011};
   int               n_mismatch = 0;
   int               cmp_count = 0;

   sram_pin_ctrl #(.ADDR_W(AW), .LANES(8)) i_dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_clock_qualify_n(cen_n),
      .i_chip_sel_low_a(sel[2]), .i_chip_sel_high(sel[1]), .i_chip_sel_low_b(sel[0]),
      .i_write_req_n(we_n), .i_advance_or_load(adv), .i_byte_write_sel_n(bw_n),
      .i_out_en_n(oe_n), .i_burst_mode(i_burst_mode), .i_dq(bus[63:0]), .o_dq(o_dq),
      .o_dq_oe_n(o_dq_oe_n), .i_parity_io(bus[71:64]), .o_parity_io(o_parity_io),
      .o_parity_io_oe_n(o_parity_io_oe_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
      .o_hresp(o_hresp),
      .o_log_ready(o_log_ready));

   sram_ctrl_model #(.AW(AW)) i_mc (
      .i_clk(i_clk), .i_dev_dq({o_parity_io, o_dq}), .i_dq_oe_n(o_dq_oe_n),
      .i_par_oe_n(o_parity_io_oe_n), .o_addr(addr), .o_cen_n(cen_n), .o_sel(sel),
      .o_we_n(we_n), .o_adv(adv), .o_bw_n(bw_n), .o_oe_n(oe_n), .o_bus(bus));

   always #2 i_clk = ~i_clk;

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   function automatic logic [71:0] pat(input logic [1:0] k);
      return {6'h2c, k, {8{6'h15, k}}};
   endfunction : pat

   // Byte lane l carries dq[8l+7:8l] and parity bit l
   function automatic logic [71:0] merge(input logic [71:0] o, input logic [71:0] n,
                                         input logic [7:0] bw);
      for (int l = 0; l < 8; l++) begin
         if (!bw[l]) begin
            o[8*l +: 8] = n[8*l +: 8];
            o[64+l] = n[64+l];
         end
      end
      return o;
   endfunction : merge

   // ------------------------------------------------------------
   // Bus and pin tasks
   // ------------------------------------------------------------
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_hreadyout !== 1'b1 && n < 20);
      if (o_hreadyout !== 1'b1) begin
         n_mismatch++;
         finish_test();
      end
   endtask : wait_rdy

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_clk);
      i_hsel <= 1'b1;
      i_haddr <= {24'h0, a};
      i_htrans <= 2'b10;
      i_hwrite <= wr;
      wait_rdy();
      i_hsel <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= wd;
      wait_rdy();
      r = o_hrdata;
      chk(o_hresp, HRESP_OKAY);
   endtask : ahb

   task automatic pin(input logic [2:0] s, input logic a_l, input logic w_n,
                      input logic [7:0] bw, input logic [AW-1:0] a, input logic drv,
                      input logic [71:0] wd);
      i_mc.beat(1'b0, s, a_l, w_n, bw, a, drv, wd);
   endtask : pin

   task automatic desel(input logic drv, input logic [71:0] wd);
      pin(3'b110, 1'b0, 1'b1, 8'hff, '0, drv, wd);
   endtask : desel

   task automatic wr(input logic [AW-1:0] a, input logic [7:0] bw, input logic [71:0] d);
      pin(SEL, 1'b0, 1'b0, bw, a, 1'b0, '0);
      chk(o_dq_oe_n, 1'b1);
      desel(1'b1, d);
      chk(o_dq_oe_n, 1'b1);
   endtask : wr

   task automatic rd(input logic [AW-1:0] a, input logic [71:0] exp);
      pin(SEL, 1'b0, 1'b1, 8'hff, a, 1'b0, '0);
      chk(o_dq_oe_n, 1'b1);
      desel(1'b0, '0);
      chk(o_dq_oe_n, 1'b1);
      desel(1'b0, '0);
      chk({o_parity_io_oe_n, o_dq_oe_n}, 2'b00);
      chk(bus, exp);
      desel(1'b0, '0);
      chk(o_dq_oe_n, 1'b1);
   endtask : rd

   // Load at base b, four advances so the count wraps, then deselect
   task automatic burst(input logic il, input logic [1:0] b);
      for (int k = 0; k <= 6; k++) begin
         if (k >= 5) desel(1'b0, '0);
         else pin(SEL, k > 0, 1'b1, 8'hff, {4'h2, b}, 1'b0, '0);
         if (k > 1) chk(bus, pat(il ? b ^ 2'(k - 2) : b + 2'(k - 2)));
      end
      desel(1'b0, '0);
   endtask : burst

   task automatic rst(input logic m);
      i_rst_n <= 1'b0;
      i_burst_mode <= m;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
   endtask : rst

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      i_hsel = 1'b0;
      i_haddr = '0;
      i_htrans = 2'b00;
      i_hwrite = 1'b0;
      i_hsize = 3'b010;
      i_hwdata = '0;
      rst(1'b0);
      wr(6'h05, 8'h00, pat(2'd1));
      wr(6'h05, 8'h5a, pat(2'd2));
      wr(6'h06, 8'h00, pat(2'd3));
      rd(6'h05, merge(pat(2'd1), pat(2'd2), 8'h5a));
      // Unqualified edges carry a write that must not land
      pin(SEL, 1'b0, 1'b1, 8'hff, 6'h05, 1'b0, '0);
      repeat (2) i_mc.beat(1'b1, SEL, 1'b0, 1'b0, 8'h00, 6'h06, 1'b1, pat(2'd0));
      chk(o_dq_oe_n, 1'b1);
      desel(1'b0, '0);
      i_mc.beat(1'b1, 3'b110, 1'b0, 1'b1, 8'hff, '0, 1'b0, '0);
      i_mc.set_oe(1'b1);
      chk({o_parity_io_oe_n, o_dq_oe_n}, 2'b11);
      i_mc.set_oe(1'b0);
      desel(1'b0, '0);
      chk(o_dq_oe_n, 1'b0);
      chk(bus, merge(pat(2'd1), pat(2'd2), 8'h5a));
      desel(1'b0, '0);
      rd(6'h06, pat(2'd3));
      pin(SEL, 1'b0, 1'b1, 8'hff, 6'h06, 1'b0, '0);
      wr(6'h07, 8'h00, pat(2'd0));
      foreach (bad[i]) begin
         pin(bad[i], 1'b0, 1'b1, 8'hff, 6'h06, 1'b0, '0);
         pin(SEL, 1'b1, 1'b1, 8'hff, 6'h06, 1'b0, '0);
         desel(1'b0, '0);
         chk(o_dq_oe_n, 1'b1);
         desel(1'b0, '0);
         chk(o_dq_oe_n, 1'b1);
      end
      for (int k = 0; k < 4; k++) wr(6'h08 + AW'(k), 8'h00, pat(2'(k)));
      burst(1'b0, 2'd1);
      ahb(1'b0, OFF_STATUS, '0);
      chk(r[STS_IL_BIT], 1'b0);
      ahb(1'b1, OFF_CTRL, WORD_ONE);
      ahb(1'b0, OFF_STATUS, '0);
      chk(r[STS_IL_BIT], 1'b1);
      burst(1'b1, 2'd1);
      rst(1'b1);
      ahb(1'b0, OFF_CTRL, '0);
      chk(r, WORD_ZERO);
      ahb(1'b0, OFF_STATUS, '0);
      chk(r[STS_IL_BIT], 1'b1);
      burst(1'b1, 2'd2);
      // Fill the write log past its depth, SRAM side cannot stall
      for (int k = 0; k < 9; k++) begin
         wr(AW'(k), 8'hff, '0);
         if (k == 8) chk(o_log_ready, 1'b0);
      end
      ahb(1'b0, OFF_WR_COUNT, '0);
      chk(r, 32'h0000_0009);
      ahb(1'b0, OFF_LOG_LEVEL, '0);
      chk(r, 32'h0000_0008);
      ahb(1'b0, OFF_STATUS, '0);
      chk(r[STS_OVF_BIT], 1'b1);
      for (int k = 0; k < 9; k++) begin
         ahb(1'b0, OFF_LOG_DATA, '0);
         chk(r, (k < 8) ? 32'(k) : WORD_ZERO);
      end
      chk(o_log_ready, 1'b1);
      ahb(1'b1, OFF_STATUS, 32'h0000_0008);
      ahb(1'b0, OFF_STATUS, '0);
      chk(r[STS_OVF_BIT], 1'b0);
      ahb(1'b0, 8'h20, '0);
      chk(r, WORD_ZERO);
      finish_test();
   end
endmodule : testbench
